// [design/iseq_defines.svh]
// Constants of the instruction sequencer and program counter
`ifndef ISEQ_DEFINES_SVH
`define ISEQ_DEFINES_SVH

`define ISEQ_PC_W 10
`define ISEQ_INSTR_W 14
`define ISEQ_ADDR_W 7
`define ISEQ_DATA_W 8
`define ISEQ_PCL_OFFSET 7'h06
`define ISEQ_PC_RESET 10'h000
`define ISEQ_VEC_EXT 10'h004
`define ISEQ_VEC_TMR 10'h008
`define ISEQ_INSTR_RESET 14'h0000
`define ISEQ_PHASES 4
`define ISEQ_PCL_LSB 0
`define ISEQ_PCL_MSB 7
`define ISEQ_BLK_LSB 8
`define ISEQ_BLK_MSB 9
`define ISEQ_TGT_LSB 0
`define ISEQ_TGT_MSB 9

`endif

// [design/iseq_pkg.sv]
// Types of the instruction sequencer and program counter
`include "iseq_defines.svh"

package iseq_pkg;

   typedef logic [`ISEQ_PC_W-1:0] iseq_pc_t;
   typedef logic [`ISEQ_INSTR_W-1:0] iseq_instr_t;
   typedef logic [`ISEQ_DATA_W-1:0] iseq_byte_t;
   typedef logic [`ISEQ_ADDR_W-1:0] iseq_addr_t;

   // Four clock phases of one instruction cycle, Gray coded
   typedef enum logic [1:0] {
      ISEQ_PH1 = 2'h0,
      ISEQ_PH2 = 2'h1,
      ISEQ_PH3 = 2'h3,
      ISEQ_PH4 = 2'h2
   } iseq_phase_t;

   // Source of the counter load at the end of a cycle
   typedef enum logic [2:0] {
      ISEQ_LD_SEQ = 3'h0,
      ISEQ_LD_SKIP = 3'h1,
      ISEQ_LD_JUMP = 3'h3,
      ISEQ_LD_CALL = 3'h2,
      ISEQ_LD_RET = 3'h6,
      ISEQ_LD_PCL = 3'h7,
      ISEQ_LD_EXT = 3'h5,
      ISEQ_LD_TMR = 3'h4
   } iseq_load_t;

endpackage

// [design/iseq_top.sv]
// Instruction sequencer: four-phase cycle, fetch pipeline and program counter
//
// Overview of operation
// - Four phases make one instruction cycle
// - Fetch overlaps execute of previous instruction
// - Counter-changing instructions take two cycles
// - Counter increments by one after each fetch
// - Counter loads on every control transfer
// - Taken skip discards fetched word, adds two
// - Low counter byte readable, writable at 06H
// - Low-byte write jumps within current block
// - Counter spans whole program memory
// - Reset clears counter to 000H
// - External interrupt loads vector 004H
// - Timer interrupt loads vector 008H
// - Calls, interrupts push; return pops counter
`timescale 1ns/100ps
`default_nettype none

`include "iseq_defines.svh"

module iseq_top
   import iseq_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // Program memory
   output logic [`ISEQ_PC_W-1:0] ROM_ADDR,
   input wire logic [`ISEQ_INSTR_W-1:0] ROM_DATA,
   // Instruction handed to decode and execute
   output logic [`ISEQ_INSTR_W-1:0] INSTR,
   output logic INSTR_VALID,
   output logic [1:0] PHASE,
   // Outcome of the executing instruction, valid in the last phase
   input wire logic DO_JUMP,
   input wire logic DO_CALL,
   input wire logic DO_RET,
   input wire logic SKIP_TAKEN,
   // Interrupt requests, already masked and enabled
   input wire logic INT_EXT_REQ,
   input wire logic INT_TMR_REQ,
   output logic INT_EXT_ACK,
   output logic INT_TMR_ACK,
   // Stack
   input wire logic STACK_FULL,
   input wire logic [`ISEQ_PC_W-1:0] STACK_TOP,
   output logic STACK_PUSH,
   output logic STACK_POP,
   output logic [`ISEQ_PC_W-1:0] STACK_DATA,
   // Register port
   input wire logic [`ISEQ_ADDR_W-1:0] REG_ADDR,
   input wire logic [`ISEQ_DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [`ISEQ_DATA_W-1:0] REG_RDATA
);

   // Phase counter
   iseq_phase_t phase_q;
   iseq_phase_t phase_d;
   logic last_phase;

   // Pipeline and counter
   iseq_pc_t pc_q;
   iseq_pc_t pc_d;
   iseq_instr_t exec_q;
   iseq_instr_t exec_d;
   logic valid_q;
   logic valid_d;

   // Pending low-byte write
   logic pend_q;
   logic pend_d;
   iseq_byte_t pend_data_q;
   iseq_byte_t pend_data_d;

   // Stack and interrupt strobes
   logic push_q;
   logic push_d;
   logic pop_q;
   logic pop_d;
   iseq_pc_t stack_data_q;
   iseq_pc_t stack_data_d;
   logic ext_ack_q;
   logic ext_ack_d;
   logic tmr_ack_q;
   logic tmr_ack_d;

   // Register read data
   iseq_byte_t rdata_q;
   iseq_byte_t rdata_d;

   // Decisions
   logic pcl_hit;
   logic pcl_wr;
   iseq_byte_t pcl_val;
   iseq_load_t load_sel;
   iseq_pc_t next_seq;
   iseq_pc_t jump_tgt;
   iseq_pc_t pcl_tgt;

   // Phase sequencing
   // Gray order: one bit flips per phase step
   always_comb begin
      case (phase_q)
         ISEQ_PH1: begin
            phase_d = ISEQ_PH2;
         end
         ISEQ_PH2: begin
            phase_d = ISEQ_PH3;
         end
         ISEQ_PH3: begin
            phase_d = ISEQ_PH4;
         end
         ISEQ_PH4: begin
            phase_d = ISEQ_PH1;
         end
         default: begin
            phase_d = ISEQ_PH1;
         end
      endcase
   end

   // Counter and pipeline move only on the edge that ends phase 4
   assign last_phase = (phase_q == ISEQ_PH4);

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         phase_q <= ISEQ_PH1;
      end else begin
         phase_q <= phase_d;
      end
   end

   // Register port decode
   // Only the low counter byte is mapped; any other address reads back zero
   assign pcl_hit = (REG_ADDR == `ISEQ_PCL_OFFSET);
   assign pcl_wr = REG_WR && pcl_hit;

   // A write in the boundary cycle itself is taken at once, so none is lost
   // Earlier writes wait for the boundary; of several, the last one wins
   assign pcl_val = pcl_wr ? REG_WDATA : pend_data_q;

   always_comb begin
      pend_d = pend_q;
      pend_data_d = pend_data_q;
      if (last_phase) begin
         pend_d = 1'b0;
      end else if (pcl_wr) begin
         pend_d = 1'b1;
         pend_data_d = REG_WDATA;
      end
      rdata_d = 8'h00;
      if (REG_RD && pcl_hit) begin
         rdata_d = pc_q[`ISEQ_PCL_MSB:`ISEQ_PCL_LSB];
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         pend_q <= 1'b0;
         pend_data_q <= 8'h00;
         rdata_q <= 8'h00;
      end else begin
         pend_q <= pend_d;
         pend_data_q <= pend_data_d;
         rdata_q <= rdata_d;
      end
   end

   // Load selection; a dummy cycle executes nothing and so triggers nothing except a low-byte write
   // Priority: return, call, jump, low-byte write, skip, external, timer
   // A transfer that wins over a pending low-byte write drops that write
   // Interrupts are not latched here: the request must stay up until acknowledged
   always_comb begin
      load_sel = ISEQ_LD_SEQ;
      if (valid_q && DO_RET) begin
         load_sel = ISEQ_LD_RET;
      end else if (valid_q && DO_CALL) begin
         load_sel = ISEQ_LD_CALL;
      end else if (valid_q && DO_JUMP) begin
         load_sel = ISEQ_LD_JUMP;
      end else if (pend_q || pcl_wr) begin
         load_sel = ISEQ_LD_PCL;
      end else if (valid_q && SKIP_TAKEN) begin
         load_sel = ISEQ_LD_SKIP;
      end else if (valid_q && INT_EXT_REQ && !STACK_FULL) begin
         load_sel = ISEQ_LD_EXT;
      end else if (valid_q && INT_TMR_REQ && !STACK_FULL) begin
         load_sel = ISEQ_LD_TMR;
      end
   end

   // The counter holds the address being fetched in this cycle
   // The increment wraps from the top of program memory back to 000H
   assign next_seq = pc_q + 10'h001;
   assign jump_tgt = exec_q[`ISEQ_TGT_MSB:`ISEQ_TGT_LSB];
   assign pcl_tgt = {pc_q[`ISEQ_BLK_MSB:`ISEQ_BLK_LSB], pcl_val};

   // Pipeline advance at the end of each instruction cycle
   // The pushed return address is the fetch that the transfer discards,
   // so execution resumes exactly at the word that was thrown away
   always_comb begin
      pc_d = pc_q;
      exec_d = exec_q;
      valid_d = valid_q;
      push_d = 1'b0;
      pop_d = 1'b0;
      stack_data_d = stack_data_q;
      ext_ack_d = 1'b0;
      tmr_ack_d = 1'b0;
      if (last_phase) begin
         // Fetched word moves to execute; a transfer turns it into a dummy
         exec_d = ROM_DATA;
         valid_d = 1'b0;
         case (load_sel)
            ISEQ_LD_SEQ: begin
               valid_d = 1'b1;
               pc_d = next_seq;
            end
            ISEQ_LD_SKIP: begin
               // Fetched word is dropped, so the next fetch lands two past the skip
               pc_d = next_seq;
            end
            ISEQ_LD_JUMP: begin
               pc_d = jump_tgt;
            end
            ISEQ_LD_CALL: begin
               pc_d = jump_tgt;
               push_d = 1'b1;
               stack_data_d = pc_q;
            end
            ISEQ_LD_RET: begin
               pc_d = STACK_TOP;
               pop_d = 1'b1;
            end
            ISEQ_LD_PCL: begin
               pc_d = pcl_tgt;
            end
            ISEQ_LD_EXT: begin
               pc_d = `ISEQ_VEC_EXT;
               push_d = 1'b1;
               stack_data_d = pc_q;
               ext_ack_d = 1'b1;
            end
            ISEQ_LD_TMR: begin
               pc_d = `ISEQ_VEC_TMR;
               push_d = 1'b1;
               stack_data_d = pc_q;
               tmr_ack_d = 1'b1;
            end
            default: begin
               pc_d = next_seq;
            end
         endcase
      end
   end

   // Reset starts fetching at 000H with a dummy in execute
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         pc_q <= `ISEQ_PC_RESET;
         exec_q <= `ISEQ_INSTR_RESET;
         valid_q <= 1'b0;
         push_q <= 1'b0;
         pop_q <= 1'b0;
         stack_data_q <= `ISEQ_PC_RESET;
         ext_ack_q <= 1'b0;
         tmr_ack_q <= 1'b0;
      end else begin
         pc_q <= pc_d;
         exec_q <= exec_d;
         valid_q <= valid_d;
         push_q <= push_d;
         pop_q <= pop_d;
         stack_data_q <= stack_data_d;
         ext_ack_q <= ext_ack_d;
         tmr_ack_q <= tmr_ack_d;
      end
   end

   // Outputs straight from flip-flops
   assign ROM_ADDR = pc_q;
   assign INSTR = exec_q;
   assign INSTR_VALID = valid_q;
   assign PHASE = phase_q;

   // Interrupt and stack strobes last one clock, in phase 1
   assign INT_EXT_ACK = ext_ack_q;
   assign INT_TMR_ACK = tmr_ack_q;
   assign STACK_PUSH = push_q;
   assign STACK_POP = pop_q;
   assign STACK_DATA = stack_data_q;

   // Read data stands for one clock after the read strobe, zero otherwise
   assign REG_RDATA = rdata_q;

endmodule

`default_nettype wire

// [sim/iseq_rom.sv]
// Program memory model that answers every fetch address with a word derived from that address
`timescale 1ns/100ps
`default_nettype none
module iseq_rom
   import iseq_pkg::*;
(
   // Fetch port
   input wire iseq_pc_t rom_addr,
   output wire iseq_instr_t rom_data
);
   // The word mixes in the address, so a wrong fetch address shows up in the executed word
   assign rom_data = {4'h5, rom_addr ^ 10'h2A5};
endmodule
`default_nettype wire

// [sim/iseq_top_asserts.sv]
// Checker of phase order, counter loads and the low counter byte register
`timescale 1ns/100ps
`default_nettype none
module iseq_top_asserts
   import iseq_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // Sequencer
   input wire iseq_pc_t ROM_ADDR,
   input wire iseq_instr_t INSTR,
   input wire logic INSTR_VALID,
   input wire logic [1:0] PHASE,
   input wire logic DO_JUMP,
   input wire logic DO_CALL,
   input wire logic DO_RET,
   input wire logic SKIP_TAKEN,
   input wire logic INT_EXT_REQ,
   input wire logic INT_TMR_REQ,
   input wire logic INT_EXT_ACK,
   input wire logic INT_TMR_ACK,
   // Stack
   input wire logic STACK_FULL,
   input wire iseq_pc_t STACK_TOP,
   input wire logic STACK_PUSH,
   input wire logic STACK_POP,
   input wire iseq_pc_t STACK_DATA,
   // Register port
   input wire iseq_addr_t REG_ADDR,
   input wire iseq_byte_t REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire iseq_byte_t REG_RDATA
);
   logic wr_waits;
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (RESET);
   // A low-byte write before phase 4 waits in the design and lands at the boundary
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         wr_waits <= 1'b0;
      end else if (PHASE == 2'h2) begin
         wr_waits <= 1'b0;
      end else if (REG_WR && REG_ADDR == 7'h06) begin
         wr_waits <= 1'b1;
      end
   end
   sequence ends_s;
      PHASE == 2'h2 && INSTR_VALID;
   endsequence
   sequence calm_s;
      ends_s ##0 (!DO_JUMP && !DO_CALL && !DO_RET && !REG_WR && !wr_waits);
   endsequence
   phase_order_a: assert property (PHASE == 2'h2 |=>
      PHASE == 2'h0 ##1 PHASE == 2'h1 ##1 PHASE == 2'h3 ##1 PHASE == 2'h2)
      else $error("phase order broken");
   addr_hold_a: assert property (PHASE != 2'h2 |=> $stable(ROM_ADDR))
      else $error("fetch address moved mid cycle");
   seq_incr_a: assert property (calm_s ##0 (!SKIP_TAKEN && !INT_EXT_REQ)
      ##0 !INT_TMR_REQ |=> ROM_ADDR == $past(ROM_ADDR) + 10'h001 && INSTR_VALID)
      else $error("no increment");
   jump_load_a: assert property (ends_s ##0 (DO_JUMP && !DO_CALL && !DO_RET)
      |=> ROM_ADDR == $past(INSTR[9:0]) ##0 !INSTR_VALID [*4]) else $error("jump target wrong");
   call_push_a: assert property (ends_s ##0 (DO_CALL && !DO_RET) |=>
      STACK_PUSH && STACK_DATA == $past(ROM_ADDR) && ROM_ADDR == $past(INSTR[9:0]))
      else $error("call wrong");
   ret_pop_a: assert property (ends_s ##0 DO_RET |=>
      STACK_POP && !STACK_PUSH && ROM_ADDR == $past(STACK_TOP)) else $error("return wrong");
   skip_two_a: assert property (calm_s ##0 SKIP_TAKEN |=>
      !INSTR_VALID && ROM_ADDR == $past(ROM_ADDR) + 10'h001) else $error("skip wrong");
   ext_vec_a: assert property (calm_s ##0 (!SKIP_TAKEN && INT_EXT_REQ && !STACK_FULL) |=>
      INT_EXT_ACK && STACK_PUSH && STACK_DATA == $past(ROM_ADDR) && ROM_ADDR == 10'h004)
      else $error("vector wrong");
   tmr_vec_a: assert property (calm_s ##0 (!SKIP_TAKEN && !INT_EXT_REQ && INT_TMR_REQ)
      ##0 !STACK_FULL |=> INT_TMR_ACK && STACK_PUSH && STACK_DATA == $past(ROM_ADDR)
      && ROM_ADDR == 10'h008) else $error("timer vector wrong");
   full_block_a: assert property (calm_s ##0 (!SKIP_TAKEN && STACK_FULL)
      |=> !STACK_PUSH && !INT_EXT_ACK && !INT_TMR_ACK && ROM_ADDR == $past(ROM_ADDR) + 10'h001)
      else $error("interrupt taken with full stack");
   pcl_read_a: assert property (REG_RD |=> REG_RDATA ==
      ($past(REG_ADDR) == 7'h06 ? $past(ROM_ADDR[7:0]) : 8'h00)) else $error("read data wrong");
   pcl_write_a: assert property (PHASE == 2'h2 && REG_WR && REG_ADDR == 7'h06
      && !(INSTR_VALID && (DO_JUMP || DO_CALL || DO_RET))
      |=> ROM_ADDR == {$past(ROM_ADDR[9:8]), $past(REG_WDATA)}) else $error("short jump wrong");
endmodule
bind iseq_top iseq_top_asserts i_iseq_top_asserts (.*);
`default_nettype wire

// [sim/iseq_top_tb.sv]
// Self-checking bench of the instruction sequencer
`timescale 1ns/100ps
`default_nettype none
module iseq_top_tb
   import iseq_pkg::*;
;
   logic clock, reset, do_jump, do_call, do_ret, skip_taken, int_ext_req, int_tmr_req;
   logic instr_valid, int_ext_ack, int_tmr_ack, stack_full, stack_push, stack_pop;
   logic reg_wr, reg_rd, rd_seen, vld;
   logic [1:0] phase;
   logic [15:0] lf;
   logic [24:0] ex, got;
   iseq_pc_t rom_addr, stack_top, stack_data, pc;
   iseq_instr_t rom_data, instr, ir;
   iseq_addr_t reg_addr;
   iseq_byte_t reg_wdata, reg_rdata;
   logic [24:0] exp_q[$];
   iseq_byte_t rd_q[$];
   int error_cnt = 0;
   int compares = 0;
   iseq_top i_iseq_top (.CLOCK(clock), .RESET(reset), .ROM_ADDR(rom_addr), .ROM_DATA(rom_data),
      .INSTR(instr), .INSTR_VALID(instr_valid), .PHASE(phase), .DO_JUMP(do_jump),
      .DO_CALL(do_call), .DO_RET(do_ret), .SKIP_TAKEN(skip_taken), .INT_EXT_REQ(int_ext_req),
      .INT_TMR_REQ(int_tmr_req), .INT_EXT_ACK(int_ext_ack), .INT_TMR_ACK(int_tmr_ack),
      .STACK_FULL(stack_full), .STACK_TOP(stack_top), .STACK_PUSH(stack_push),
      .STACK_POP(stack_pop), .STACK_DATA(stack_data), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
   iseq_rom i_iseq_rom (.rom_addr(rom_addr), .rom_data(rom_data));
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic check(input string what, input logic [24:0] seen, input logic [24:0] want);
      compares++;
      if (seen !== want) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic stop_test;
      if (error_cnt == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // One instruction cycle: outcome inputs are placed in phase 4, where they are sampled
   task automatic step;
      int n;
      int k;
      iseq_addr_t a;
      iseq_instr_t nw;
      logic tr;
      n = 0;
      lf = lfsr(lf);
      k = int'(lf[7:5]);
      a = lf[4] ? 7'h06 : lf[14:8];
      do begin
         @(posedge clock);
         n++;
         // A low-byte write may also come in phase 3 and wait for the cycle boundary
         if (phase === 2'h1 && k == 7 && lf[0]) begin
            reg_wr <= 1'b1;
            reg_addr <= 7'h06;
            reg_wdata <= lf[15:8];
         end
      end while (phase !== 2'h3 && n < 8);
      if (n >= 8) begin
         error_cnt++;
         stop_test;
      end
      do_jump <= k == 1;
      do_call <= k == 2;
      do_ret <= k == 3;
      skip_taken <= k == 4;
      int_ext_req <= k == 5;
      int_tmr_req <= k == 6 || (k == 5 && lf[1]);
      stack_full <= lf[2];
      stack_top <= lf[9:0];
      reg_wr <= k == 7 && !lf[0];
      reg_wdata <= lf[15:8];
      reg_rd <= k != 7 && lf[3];
      reg_addr <= k == 7 ? 7'h06 : a;
      if (k != 7 && lf[3]) rd_q.push_back(a == 7'h06 ? pc[7:0] : 8'h00);
      tr = (vld && (k inside {[1:4]} || (k >= 5 && !lf[2]))) || k == 7;
      // ir still holds the word in execute, whose field is the jump target
      nw = {4'h5, pc ^ 10'h2A5};
      if (vld && k == 3) pc = lf[9:0];
      else if (vld && (k == 1 || k == 2)) pc = ir[9:0];
      else if (k == 7) pc = {pc[9:8], lf[15:8]};
      else if (vld && k == 5 && !lf[2]) pc = 10'h004;
      else if (vld && k == 6 && !lf[2]) pc = 10'h008;
      else pc = pc + 10'h001;
      ir = nw;
      vld = !tr;
      exp_q.push_back({vld, vld ? ir : 14'h0000, pc});
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask
   always @(posedge clock) begin
      if (!reset && phase === 2'h1 && exp_q.size() > 0) begin
         ex = exp_q.pop_front();
         got = {instr_valid, instr_valid ? instr : 14'h0000, rom_addr};
         check("fetch", got, ex);
      end
      if (rd_seen) check("read", {17'h00000, reg_rdata}, {17'h00000, rd_q.pop_front()});
      rd_seen <= reg_rd;
   end
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      {reset, do_jump, do_call, do_ret, skip_taken, int_ext_req, int_tmr_req} = 7'h40;
      {stack_full, reg_wr, reg_rd, rd_seen, vld} = 5'h00;
      {stack_top, pc, reg_addr, reg_wdata, ir} = 49'h0;
      lf = 16'h005E;
      repeat (12) @(posedge clock);
      check("reset address", {15'h0000, rom_addr}, 25'h0000000);
      reset <= 1'b0;
      for (int i = 0; i < 200; i++) step;
      repeat (8) @(posedge clock);
      stop_test;
   end
endmodule
`default_nettype wire
